/* bfcu_core.sv */
// branch resolution, target generation, cr logic, traps and cr-move steering
`timescale 1ns/1ns
module bfcu_core (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               op_valid_i,
  input  wire bfcu_pkg::bfcu_req_t op_i,
  output logic                    op_ready_o,
  input  wire logic [31:0]        cr_pend_set_i,
  input  wire logic [31:0]        cr_wr_en_i,
  input  wire logic [31:0]        cr_wr_data_i,
  input  wire logic               multi_cycle_integer_unit_done_i,
  input  wire logic               lr_wr_i,
  input  wire logic               ctr_wr_i,
  input  wire logic [63:0]        spr_wdata_i,
  output bfcu_pkg::bfcu_res_t     res_o,
  output logic                    flush_o,
  output bfcu_pkg::bfcu_iss_t     issue_o,
  output logic                    trap_o,
  output logic                    sc_o,
  output logic                    invalid_o,
  output logic [63:0]             exc_pc_o,
  output logic [31:0]             cr_o,
  output logic                    sb_o,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [31:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o
);
  // target address for the six modes, word aligned
  function automatic logic [63:0] tgt_calc(bfcu_pkg::bfcu_tmode_t m, logic [63:0] cia,
                                           logic [63:0] disp, logic [63:0] lr, logic [63:0] ctr);
    logic [63:0] t;
    unique case (m)
      bfcu_pkg::TM_REL, bfcu_pkg::TM_CREL: t = cia + disp;
      bfcu_pkg::TM_ABS, bfcu_pkg::TM_CABS: t = disp;
      bfcu_pkg::TM_CLR:                    t = lr;
      default:                             t = ctr;
    endcase
    return t & bfcu_pkg::ALIGN_MASK;
  endfunction
  // trap condition evaluation
  function automatic logic trap_hit(logic [4:0] to, logic [63:0] a, logic [63:0] b,
                                    logic wide);
    logic slt, sgt, ult, ugt, eq;
    slt = wide ? ($signed(a) < $signed(b)) : ($signed(a[31:0]) < $signed(b[31:0]));
    sgt = wide ? ($signed(a) > $signed(b)) : ($signed(a[31:0]) > $signed(b[31:0]));
    ult = wide ? (a < b) : (a[31:0] < b[31:0]);
    ugt = wide ? (a > b) : (a[31:0] > b[31:0]);
    eq  = wide ? (a == b) : (a[31:0] == b[31:0]);
    return (to[bfcu_pkg::TO_LT] & slt) | (to[bfcu_pkg::TO_GT] & sgt) |
           (to[bfcu_pkg::TO_EQ] & eq) | (to[bfcu_pkg::TO_LTU] & ult) |
           (to[bfcu_pkg::TO_GTU] & ugt);
  endfunction
  // cr bit logic
  function automatic logic crlog_f(bfcu_pkg::bfcu_crlog_t op, logic a, logic b);
    logic r;
    unique case (op)
      bfcu_pkg::CL_AND:  r = a & b;
      bfcu_pkg::CL_OR:   r = a | b;
      bfcu_pkg::CL_XOR:  r = a ^ b;
      bfcu_pkg::CL_NAND: r = ~(a & b);
      bfcu_pkg::CL_NOR:  r = ~(a | b);
      bfcu_pkg::CL_EQV:  r = ~(a ^ b);
      bfcu_pkg::CL_ANDC: r = a & ~b;
      default:           r = a | ~b;
    endcase
    return r;
  endfunction
  // byte-lane merge for bus writes
  function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  bfcu_pkg::bfcu_state_t state_q, state_d;
  logic [4:0]  wt_bi_q, wt_bi_d;
  logic        wt_sense_q, wt_sense_d;
  logic        wt_pred_q, wt_pred_d;
  logic [63:0] wt_tgt_q, wt_tgt_d;
  logic [63:0] wt_fall_q, wt_fall_d;
  logic [63:0] lr_q, lr_d;
  logic [63:0] ctr_q, ctr_d;
  logic [31:0] cr_q, cr_d;
  logic [31:0] pend_q, pend_d;
  logic        sb_q, sb_d;
  logic        single_cycle_integer_unit_q, single_cycle_integer_unit_d;
  logic [3:0]  tag_q, tag_d;
  logic [31:0] miss_q, miss_d;
  bfcu_pkg::bfcu_res_t res_q, res_d;
  bfcu_pkg::bfcu_iss_t iss_q, iss_d;
  logic        flush_q, flush_d;
  logic        trap_q, trap_d;
  logic        sc_q, sc_d;
  logic        inv_q, inv_d;
  logic [63:0] exc_q, exc_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        is_cond, single, sb_class, pend_stall, br_wait;
  logic        wt_hit, stall, accept, bus_wr;
  logic [31:0] cr_now;
  logic [63:0] fall, tgt, opb_v;

  // dispatch admission: scoreboard, pending producers and waiting branch
  always_comb begin
    is_cond  = (op_i.mode != bfcu_pkg::TM_REL) && (op_i.mode != bfcu_pkg::TM_ABS);
    single   = $onehot(op_i.fmask);
    wt_hit   = (state_q == bfcu_pkg::ST_WAIT_BIT) && cr_wr_en_i[wt_bi_q];
    sb_class = ((op_i.cls == bfcu_pkg::OP_MTCRF) && !single) ||
               (op_i.cls == bfcu_pkg::OP_MTCTR) || (op_i.cls == bfcu_pkg::OP_MTLR) ||
               ((op_i.cls == bfcu_pkg::OP_BRANCH) && is_cond) ||
               (op_i.cls == bfcu_pkg::OP_CRLOG) || (op_i.cls == bfcu_pkg::OP_MCRF);
    cr_now  = (cr_q & ~cr_wr_en_i) | (cr_wr_data_i & cr_wr_en_i); // a same-cycle write settles
    br_wait = is_cond && pend_q[op_i.bi] && !cr_wr_en_i[op_i.bi];
    unique case (op_i.cls)
      bfcu_pkg::OP_BRANCH: pend_stall = state_q == bfcu_pkg::ST_WAIT_BIT;
      bfcu_pkg::OP_CRLOG:  pend_stall = pend_q[op_i.cra] | pend_q[op_i.crb];
      bfcu_pkg::OP_MCRF:   pend_stall = |pend_q[4*op_i.cra[4:2] +: 4];
      default:             pend_stall = 1'b0;
    endcase
    stall  = (sb_q && sb_class) || pend_stall || wt_hit;
    accept = op_valid_i && !stall;
    fall   = (op_i.cia + bfcu_pkg::INSTR_BYTES) & bfcu_pkg::ALIGN_MASK;
    tgt    = tgt_calc(op_i.mode, op_i.cia, op_i.disp, lr_q, ctr_q);
    opb_v  = op_i.use_imm ? {{48{op_i.simm[15]}}, op_i.simm} : op_i.opb;
    bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  end
  assign op_ready_o = !stall;

  // next state of the unit
  always_comb begin
    state_d    = state_q;
    wt_bi_d    = wt_bi_q;
    wt_sense_d = wt_sense_q;
    wt_pred_d  = wt_pred_q;
    wt_tgt_d   = wt_tgt_q;
    wt_fall_d  = wt_fall_q;
    lr_d       = lr_wr_i ? spr_wdata_i : lr_q;
    ctr_d      = ctr_wr_i ? spr_wdata_i : ctr_q;
    cr_d       = (cr_q & ~cr_wr_en_i) | (cr_wr_data_i & cr_wr_en_i);
    pend_d     = (pend_q & ~cr_wr_en_i) | cr_pend_set_i;
    sb_d       = multi_cycle_integer_unit_done_i ? 1'b0 : sb_q;
    single_cycle_integer_unit_d     = single_cycle_integer_unit_q;
    tag_d      = tag_q;
    miss_d     = miss_q;
    res_d      = '0;
    iss_d      = '0;
    flush_d    = 1'b0;
    trap_d     = 1'b0;
    sc_d       = 1'b0;
    inv_d      = 1'b0;
    exc_d      = exc_q;
    // register bus writes, hardware updates take priority
    if (bus_wr) begin
      unique case (wb_adr_i[7:0])
        bfcu_pkg::OFS_LR_LO:  if (!lr_wr_i) lr_d[31:0] = wmerge(lr_q[31:0], wb_dat_i, wb_sel_i);
        bfcu_pkg::OFS_LR_HI:  if (!lr_wr_i) lr_d[63:32] = wmerge(lr_q[63:32], wb_dat_i, wb_sel_i);
        bfcu_pkg::OFS_CTR_LO: if (!ctr_wr_i) ctr_d[31:0] = wmerge(ctr_q[31:0], wb_dat_i, wb_sel_i);
        bfcu_pkg::OFS_CTR_HI: if (!ctr_wr_i) ctr_d[63:32] = wmerge(ctr_q[63:32], wb_dat_i, wb_sel_i);
        bfcu_pkg::OFS_CR:     cr_d = (wmerge(cr_q, wb_dat_i, wb_sel_i) & ~cr_wr_en_i) |
                                     (cr_wr_data_i & cr_wr_en_i);
        default: ;
      endcase
    end
    // waiting branch resolves when its producer writes the bit
    if (wt_hit) begin
      res_d.valid   = 1'b1;
      res_d.taken   = cr_wr_data_i[wt_bi_q] == wt_sense_q;
      res_d.mispred = res_d.taken != wt_pred_q;
      res_d.target  = res_d.taken ? wt_tgt_q : wt_fall_q;
      flush_d       = res_d.mispred;
      state_d       = bfcu_pkg::ST_IDLE;
    end
    if (accept) begin
      unique case (op_i.cls)
        bfcu_pkg::OP_BRANCH: begin
          iss_d = '{valid: 1'b1, unit: bfcu_pkg::U_BPU, tag: 4'h0};
          if (op_i.link) lr_d = fall;
          if (br_wait) begin
            state_d    = bfcu_pkg::ST_WAIT_BIT;
            wt_bi_d    = op_i.bi;
            wt_sense_d = op_i.sense;
            wt_pred_d  = op_i.pred_taken;
            wt_tgt_d   = tgt;
            wt_fall_d  = fall;
          end else begin
            res_d.valid   = 1'b1;
            res_d.taken   = !is_cond || (cr_now[op_i.bi] == op_i.sense);
            res_d.mispred = res_d.taken != op_i.pred_taken;
            res_d.target  = res_d.taken ? tgt : fall;
            flush_d       = res_d.mispred;
          end
        end
        bfcu_pkg::OP_CRLOG: begin
          iss_d = '{valid: 1'b1, unit: bfcu_pkg::U_BPU, tag: 4'h0};
          if (op_i.link) inv_d = 1'b1;
          else cr_d[op_i.crd] = crlog_f(op_i.crop, cr_q[op_i.cra], cr_q[op_i.crb]);
        end
        bfcu_pkg::OP_MCRF: begin
          iss_d = '{valid: 1'b1, unit: bfcu_pkg::U_BPU, tag: 4'h0};
          if (op_i.link) inv_d = 1'b1;
          else cr_d[4*op_i.crd[4:2] +: 4] = cr_q[4*op_i.cra[4:2] +: 4];
        end
        bfcu_pkg::OP_TRAP: begin
          iss_d  = '{valid: 1'b1, unit: bfcu_pkg::U_BPU, tag: 4'h0};
          trap_d = trap_hit(op_i.to, op_i.opa, opb_v, op_i.wide);
          if (trap_d) exc_d = op_i.cia;
        end
        bfcu_pkg::OP_SC: begin
          iss_d = '{valid: 1'b1, unit: bfcu_pkg::U_BPU, tag: 4'h0};
          sc_d  = 1'b1;
          exc_d = fall;
        end
        bfcu_pkg::OP_MTCRF: begin
          for (int f = 0; f < 8; f++)
            if (op_i.fmask[f]) pend_d[4*f +: 4] = 4'hF;
          if (single) begin
            iss_d.valid = 1'b1;
            iss_d.unit  = single_cycle_integer_unit_q ? bfcu_pkg::U_SCIU1 : bfcu_pkg::U_SCIU0;
            iss_d.tag   = tag_q;
            tag_d       = tag_q + 4'h1;
            single_cycle_integer_unit_d      = !single_cycle_integer_unit_q;
          end else begin
            iss_d = '{valid: 1'b1, unit: bfcu_pkg::U_MULTI_CYCLE_INTEGER_UNIT, tag: 4'h0};
            sb_d  = 1'b1;
          end
        end
        bfcu_pkg::OP_MTCTR, bfcu_pkg::OP_MTLR: begin
          iss_d = '{valid: 1'b1, unit: bfcu_pkg::U_MULTI_CYCLE_INTEGER_UNIT, tag: 4'h0};
          sb_d  = 1'b1;
        end
        default: ;
      endcase
    end
    if (res_d.mispred) miss_d = miss_q + 32'h1;
  end

  // register bus answer: ack one cycle after the request
  always_comb begin
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = 32'h0;
    unique case (wb_adr_i[7:0])
      bfcu_pkg::OFS_STATUS: begin
        rdat_d[bfcu_pkg::ST_SB]   = sb_q;
        rdat_d[bfcu_pkg::ST_WAIT] = state_q == bfcu_pkg::ST_WAIT_BIT;
      end
      bfcu_pkg::OFS_LR_LO:  rdat_d = lr_q[31:0];
      bfcu_pkg::OFS_LR_HI:  rdat_d = lr_q[63:32];
      bfcu_pkg::OFS_CTR_LO: rdat_d = ctr_q[31:0];
      bfcu_pkg::OFS_CTR_HI: rdat_d = ctr_q[63:32];
      bfcu_pkg::OFS_CR:     rdat_d = cr_q;
      bfcu_pkg::OFS_MISS:   rdat_d = miss_q;
      default:              rdat_d = 32'h0;
    endcase
    if (wb_adr_i[31:8] != 24'h0) rdat_d = 32'h0;
    if (!ack_d) rdat_d = rdat_q;
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= bfcu_pkg::ST_IDLE;
      wt_bi_q    <= 5'h0;
      wt_sense_q <= 1'b0;
      wt_pred_q  <= 1'b0;
      wt_tgt_q   <= 64'h0;
      wt_fall_q  <= 64'h0;
      lr_q       <= bfcu_pkg::LR_RST;
      ctr_q      <= bfcu_pkg::CTR_RST;
      cr_q       <= bfcu_pkg::CR_RST;
      pend_q     <= 32'h0;
      sb_q       <= 1'b0;
      single_cycle_integer_unit_q     <= 1'b0;
      tag_q      <= 4'h0;
      miss_q     <= 32'h0;
      res_q      <= '0;
      iss_q      <= '0;
      flush_q    <= 1'b0;
      trap_q     <= 1'b0;
      sc_q       <= 1'b0;
      inv_q      <= 1'b0;
      exc_q      <= 64'h0;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0;
    end else begin
      state_q    <= state_d;
      wt_bi_q    <= wt_bi_d;
      wt_sense_q <= wt_sense_d;
      wt_pred_q  <= wt_pred_d;
      wt_tgt_q   <= wt_tgt_d;
      wt_fall_q  <= wt_fall_d;
      lr_q       <= lr_d;
      ctr_q      <= ctr_d;
      cr_q       <= cr_d;
      pend_q     <= pend_d;
      sb_q       <= sb_d;
      single_cycle_integer_unit_q     <= single_cycle_integer_unit_d;
      tag_q      <= tag_d;
      miss_q     <= miss_d;
      res_q      <= res_d;
      iss_q      <= iss_d;
      flush_q    <= flush_d;
      trap_q     <= trap_d;
      sc_q       <= sc_d;
      inv_q      <= inv_d;
      exc_q      <= exc_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
    end
  end

  // outputs
  assign res_o     = res_q;
  assign flush_o   = flush_q;
  assign issue_o   = iss_q;
  assign trap_o    = trap_q;
  assign sc_o      = sc_q;
  assign invalid_o = inv_q;
  assign exc_pc_o  = exc_q;
  assign cr_o      = cr_q;
  assign sb_o      = sb_q;
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_br_now;
    accept && op_i.cls == bfcu_pkg::OP_BRANCH && !br_wait;
  endsequence
  sequence s_br_wait;
    accept && op_i.cls == bfcu_pkg::OP_BRANCH && br_wait;
  endsequence
  sequence s_mt_multi;
    accept && op_i.cls == bfcu_pkg::OP_MTCRF && !$onehot(op_i.fmask);
  endsequence

  chk_target_align: assert property (res_o.valid |-> res_o.target[1:0] == 2'b00)
    else $error("branch target not word aligned");
  chk_resolve_now: assert property (s_br_now |=> res_o.valid && issue_o.unit == bfcu_pkg::U_BPU)
    else $error("branch without pending producer not resolved next cycle");
  chk_wait_hold: assert property (s_br_wait |=> !res_o.valid && state_q == bfcu_pkg::ST_WAIT_BIT)
    else $error("branch with pending producer resolved early");
  chk_wait_resolve: assert property (wt_hit |=> res_o.valid && state_q == bfcu_pkg::ST_IDLE
                                     ##0 flush_o == res_o.mispred)
    else $error("waiting branch not resolved with its producer");
  chk_flush_match: assert property (flush_o |-> res_o.valid && res_o.mispred)
    else $error("flush without a mispredicted resolution");
  chk_invalid_form: assert property (accept && op_i.link && (op_i.cls == bfcu_pkg::OP_CRLOG ||
                                     op_i.cls == bfcu_pkg::OP_MCRF) |=> invalid_o)
    else $error("cr op with link update not flagged invalid");
  chk_sb_set: assert property (s_mt_multi |=> sb_o && issue_o.unit == bfcu_pkg::U_MULTI_CYCLE_INTEGER_UNIT)
    else $error("multi-field move did not set scoreboard");
  chk_sb_hold: assert property (sb_q && op_valid_i && sb_class |-> !op_ready_o)
    else $error("scoreboard-held op dispatched under scoreboard");
  chk_sb_clear: assert property (multi_cycle_integer_unit_done_i && !(accept && sb_class && op_i.cls inside
                                 {bfcu_pkg::OP_MTCRF, bfcu_pkg::OP_MTCTR, bfcu_pkg::OP_MTLR})
                                 |=> !sb_o)
    else $error("scoreboard not cleared on completion");
  chk_single_single_cycle_integer_unit: assert property (accept && op_i.cls == bfcu_pkg::OP_MTCRF && $onehot(op_i.fmask)
                                    |=> issue_o.unit inside {bfcu_pkg::U_SCIU0, bfcu_pkg::U_SCIU1}
                                    && !$changed(sb_o))
    else $error("single-field move not steered to a single-cycle unit");
  chk_sc_raise: assert property (accept && op_i.cls == bfcu_pkg::OP_SC |=> sc_o ##1 !sc_o)
    else $error("system call not raised for exactly one cycle");
  chk_trap_quiet: assert property (accept && op_i.cls == bfcu_pkg::OP_TRAP && op_i.to == 5'h0
                                   |=> !trap_o)
    else $error("trap raised with no condition selected");
endmodule

/* bfcu_pkg.sv */
// package: constants, types and carriers of the branch and flow-control unit
package bfcu_pkg;
  localparam int XLEN = 64;
  // register bus byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_LR_LO  = 8'h04;
  localparam logic [7:0] OFS_LR_HI  = 8'h08;
  localparam logic [7:0] OFS_CTR_LO = 8'h0C;
  localparam logic [7:0] OFS_CTR_HI = 8'h10;
  localparam logic [7:0] OFS_CR     = 8'h14;
  localparam logic [7:0] OFS_MISS   = 8'h18;
  // status bit positions
  localparam int ST_SB   = 0;
  localparam int ST_WAIT = 1;
  // reset values
  localparam logic [63:0] LR_RST  = 64'h0;
  localparam logic [63:0] CTR_RST = 64'h0;
  localparam logic [31:0] CR_RST  = 32'h0;
  // addressing
  localparam logic [63:0] INSTR_BYTES = 64'h4;
  localparam logic [63:0] ALIGN_MASK  = 64'hFFFF_FFFF_FFFF_FFFC;
  // trap condition field bit positions
  localparam int TO_LT  = 4;
  localparam int TO_GT  = 3;
  localparam int TO_EQ  = 2;
  localparam int TO_LTU = 1;
  localparam int TO_GTU = 0;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_BRANCH = 4'h1, OP_CRLOG = 4'h2, OP_MCRF = 4'h3, OP_TRAP = 4'h4,
    OP_SC = 4'h5, OP_MTCRF = 4'h6, OP_MTCTR = 4'h7, OP_MTLR = 4'h8
  } bfcu_op_t;
  typedef enum logic [2:0] {
    TM_REL = 3'h0, TM_CREL = 3'h1, TM_ABS = 3'h2, TM_CABS = 3'h3, TM_CLR = 3'h4, TM_CCTR = 3'h5
  } bfcu_tmode_t;
  typedef enum logic [2:0] {
    CL_AND = 3'h0, CL_OR = 3'h1, CL_XOR = 3'h2, CL_NAND = 3'h3,
    CL_NOR = 3'h4, CL_EQV = 3'h5, CL_ANDC = 3'h6, CL_ORC = 3'h7
  } bfcu_crlog_t;
  typedef enum logic [1:0] {
    U_BPU = 2'h0, U_SCIU0 = 2'h1, U_SCIU1 = 2'h2, U_MULTI_CYCLE_INTEGER_UNIT = 2'h3
  } bfcu_unit_t;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_WAIT_BIT = 1'b1} bfcu_state_t;

  typedef struct packed {
    bfcu_op_t    cls;
    bfcu_tmode_t mode;
    logic        link;
    logic [4:0]  bi;
    logic        sense;
    logic        pred_taken;
    logic [63:0] cia;
    logic [63:0] disp;
    bfcu_crlog_t crop;
    logic [4:0]  crd;
    logic [4:0]  cra;
    logic [4:0]  crb;
    logic [7:0]  fmask;
    logic [4:0]  to;
    logic        wide;
    logic        use_imm;
    logic [15:0] simm;
    logic [63:0] opa;
    logic [63:0] opb;
  } bfcu_req_t;
  typedef struct packed {
    logic        valid;
    logic        taken;
    logic        mispred;
    logic [63:0] target;
  } bfcu_res_t;
  typedef struct packed {
    logic       valid;
    bfcu_unit_t unit;
    logic [3:0] tag;
  } bfcu_iss_t;
endpackage

/* bfcu_exu_model.sv */
// execution-side model: cr bit producer and multi-cycle unit completion
`timescale 1ns/1ns
module bfcu_exu_model (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                go_i,
  input  wire logic [4:0]          bit_i,
  input  wire logic                val_i,
  input  wire bfcu_pkg::bfcu_iss_t issue_i,
  output logic [31:0]              cr_pend_set_o,
  output logic [31:0]              cr_wr_en_o,
  output logic [31:0]              cr_wr_data_o,
  output logic                     multi_cycle_integer_unit_done_o
);
  int unsigned cr_cnt;
  int unsigned mc_cnt;
  logic [4:0]  bit_q;
  logic        val_q;
  // pend pulse on go, write-back six cycles later; idle data toggles so no stale value shows
  always @(posedge clk_i) begin
    cr_pend_set_o <= 32'h0;
    cr_wr_en_o <= 32'h0;
    multi_cycle_integer_unit_done_o <= 1'b0;
    cr_wr_data_o <= ~cr_wr_data_o;
    if (rst_i) begin
      cr_cnt <= 0;
      mc_cnt <= 0;
      cr_wr_data_o <= 32'h0;
    end else begin
      if (go_i) begin
        cr_pend_set_o <= 32'h1 << bit_i;
        bit_q <= bit_i;
        val_q <= val_i;
        cr_cnt <= 6;
      end else if (cr_cnt == 1) begin
        cr_wr_en_o <= 32'h1 << bit_q;
        cr_wr_data_o <= {32{val_q}};
        cr_cnt <= 0;
      end else if (cr_cnt != 0) cr_cnt <= cr_cnt - 1;
      // multi-cycle unit finishes four cycles after it is handed an op
      if (issue_i.valid && issue_i.unit == bfcu_pkg::U_MULTI_CYCLE_INTEGER_UNIT) mc_cnt <= 4;
      else if (mc_cnt == 1) begin
        multi_cycle_integer_unit_done_o <= 1'b1;
        mc_cnt <= 0;
      end else if (mc_cnt != 0) mc_cnt <= mc_cnt - 1;
    end
  end
endmodule

/* tb.sv */
// testbench: dispatch and register-bus sequences with expected results
`timescale 1ns/1ns
module tb;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                op_valid_i = 1'b0;
  logic                go = 1'b0;
  bfcu_pkg::bfcu_req_t op_i = '0;
  bfcu_pkg::bfcu_req_t q;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i = 1'b0;
  logic [31:0]         wb_adr_i = 32'h0;
  logic [31:0]         wb_dat_i = 32'h0;
  logic [3:0]          wb_sel_i = 4'h0;
  logic [31:0]         cr_pend_set_i, cr_wr_en_i, cr_wr_data_i, cr_o, wb_dat_o, rd;
  logic                op_ready_o, multi_cycle_integer_unit_done_i, flush_o, trap_o, sc_o, invalid_o, sb_o, wb_ack_o;
  logic                fl, tp, sy, iv;
  logic [63:0]         exc_pc_o;
  bfcu_pkg::bfcu_res_t res_o, rs;
  bfcu_pkg::bfcu_iss_t issue_o, is, u0;
  int                  num_errors = 0, n_checks = 0, nw, cycles = 0;
  logic [63:0]         tgt [6] = '{64'h110, 64'h110, 64'h10, 64'h10, 64'hA5A5_0004, 64'h800};

  always #4 clk_i = ~clk_i;
  bfcu_core u_bfcu_core (.clk_i, .rst_i, .op_valid_i, .op_i, .op_ready_o, .cr_pend_set_i,
    .cr_wr_en_i, .cr_wr_data_i, .multi_cycle_integer_unit_done_i, .lr_wr_i(1'b0), .ctr_wr_i(1'b0),
    .spr_wdata_i(64'h0), .res_o, .flush_o, .issue_o, .trap_o, .sc_o, .invalid_o, .exc_pc_o,
    .cr_o, .sb_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);
  bfcu_exu_model u_bfcu_exu_model (.clk_i, .rst_i, .go_i(go), .bit_i(5'h2), .val_i(1'b1),
    .issue_i(issue_o), .cr_pend_set_o(cr_pend_set_i), .cr_wr_en_o(cr_wr_en_i),
    .cr_wr_data_o(cr_wr_data_i), .multi_cycle_integer_unit_done_o(multi_cycle_integer_unit_done_i));

  task chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  // classic wishbone cycle held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) num_errors++;
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // dispatch one op, held until taken; answer captured one cycle later
  task automatic disp(input bfcu_pkg::bfcu_req_t r);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= r;
    nw = 0;
    do begin @(negedge clk_i); nw++; end while (op_ready_o !== 1'b1 && nw < 50);
    if (op_ready_o !== 1'b1) num_errors++;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    @(negedge clk_i);
    {rs, fl, is, tp, sy, iv} = {res_o, flush_o, issue_o, trap_o, sc_o, invalid_o};
  endtask
  task automatic trap_case(input logic [4:0] to, input logic w, input logic im,
                           input logic [63:0] a, input logic [63:0] b, input logic e);
    q = '0;
    {q.cls, q.to, q.wide, q.use_imm, q.simm} = {bfcu_pkg::OP_TRAP, to, w, im, b[15:0]};
    {q.opa, q.opb, q.cia} = {a, b, 64'h200};
    disp(q);
    chk(tp, e);
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run;
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({sb_o, cr_o}, 0);
    wb(0, bfcu_pkg::OFS_STATUS, 0, 4'hF);
    chk(rd, 0);
    wb(1, bfcu_pkg::OFS_CR, 32'h0000_0001, 4'hF);
    wb(1, bfcu_pkg::OFS_CR, 32'hFFFF_FFFF, 4'h2);
    wb(1, bfcu_pkg::OFS_LR_LO, 32'hA5A5_0004, 4'hF);
    wb(1, bfcu_pkg::OFS_CTR_LO, 32'h0000_0803, 4'hF);
    wb(1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    wb(0, 8'h40, 0, 4'hF);
    chk(rd, 0);
    wb(0, bfcu_pkg::OFS_CR, 0, 4'hF);
    chk(rd, 32'h0000_FF01);
    // every target mode, tested bit settled and set, prediction right
    q = '0;
    {q.cls, q.sense, q.pred_taken, q.cia, q.disp} = {bfcu_pkg::OP_BRANCH, 2'b11, 64'h100, 64'h13};
    for (int i = 0; i < 6; i++) begin
      q.mode = bfcu_pkg::bfcu_tmode_t'(3'(i));
      disp(q);
      chk({rs.valid, rs.taken, rs.mispred, fl}, 4'hC);
      chk(rs.target, tgt[i]);
      chk({is.valid, is.unit}, {1'b1, bfcu_pkg::U_BPU});
    end
    // not taken against prediction: redirect just past the branch
    {q.mode, q.bi} = {bfcu_pkg::TM_CREL, 5'h1};
    disp(q);
    chk({rs.valid, rs.taken, rs.mispred, fl}, 4'hB);
    chk(rs.target, 64'h104);
    // producer in flight: branch waits for the write-back
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    {q.bi, q.pred_taken} = {5'h2, 1'b0};
    disp(q);
    chk(rs.valid, 0);
    for (int k = 0; k < 20 && res_o.valid !== 1'b1; k++) @(negedge clk_i);
    chk({res_o.valid, res_o.taken, res_o.mispred, flush_o}, 4'hF);
    chk(res_o.target, 64'h110);
    q = '0;
    {q.cls, q.link} = {bfcu_pkg::OP_CRLOG, 1'b1};
    disp(q);
    chk(iv, 1);
    trap_case(5'h04, 1, 0, 64'h5, 64'h5, 1);
    chk(exc_pc_o, 64'h200);
    trap_case(5'h10, 1, 0, 64'h5, 64'h5, 0);
    trap_case(5'h00, 1, 0, 64'h5, 64'h5, 0);
    trap_case(5'h04, 0, 0, 64'hFFFF_0000_0000_0005, 64'h5, 1);
    trap_case(5'h04, 1, 0, 64'hFFFF_0000_0000_0005, 64'h5, 0);
    trap_case(5'h08, 1, 1, 64'h0, 64'hFFFF, 1);
    q = '0;
    {q.cls, q.cia} = {bfcu_pkg::OP_SC, 64'h302};
    disp(q);
    chk({sy, tp}, 2'b10);
    chk(exc_pc_o, 64'h304);
    // single-field moves alternate units, no scoreboard
    {q.cls, q.fmask} = {bfcu_pkg::OP_MTCRF, 8'h01};
    disp(q);
    u0 = is;
    q.fmask = 8'h80;
    disp(q);
    chk({u0.unit, is.unit}, {bfcu_pkg::U_SCIU0, bfcu_pkg::U_SCIU1});
    chk(is.tag, 4'(u0.tag + 4'h1));
    chk(sb_o, 0);
    q.fmask = 8'h03;
    disp(q);
    chk({is.unit, sb_o}, {bfcu_pkg::U_MULTI_CYCLE_INTEGER_UNIT, 1'b1});
    {q.cls, q.fmask} = {bfcu_pkg::OP_MTCTR, 8'h00};
    disp(q);
    chk(nw > 1, 1);
    chk(is.unit, bfcu_pkg::U_MULTI_CYCLE_INTEGER_UNIT);
    for (int k = 0; k < 20 && sb_o !== 1'b0; k++) @(negedge clk_i);
    chk(sb_o, 0);
    {q.cls, q.fmask} = {bfcu_pkg::OP_MTCRF, 8'h00};
    disp(q);
    chk({is.unit, sb_o}, {bfcu_pkg::U_MULTI_CYCLE_INTEGER_UNIT, 1'b1});
    q.cls = bfcu_pkg::OP_MTLR;
    disp(q);
    chk(nw > 1, 1);
    complete_run;
  end
endmodule
